//--- common/port_match_pkg.sv
package port_match_pkg;

    // register byte addresses on the special function register bus
    localparam logic [7:0] PIN_LATCH_ADDR      = 8'h90;
    localparam logic [7:0] EXPECTED_LEVEL_ADDR = 8'hed;
    localparam logic [7:0] COMPARE_ENABLE_ADDR = 8'hee;
    localparam logic [7:0] OUTPUT_DRIVE_ADDR   = 8'ha5;
    localparam logic [7:0] INPUT_TYPE_ADDR     = 8'hf2;

    // bit addresses of the latch start at its byte address
    localparam logic [7:0] PIN_LATCH_BIT_BASE  = 8'h90;
    localparam int         PIN_LATCH_BIT_SPAN  = 8;

    // values after reset
    localparam logic [7:0] PIN_LATCH_RESET      = 8'hff;
    localparam logic [7:0] EXPECTED_LEVEL_RESET = 8'hff;
    localparam logic [7:0] COMPARE_ENABLE_RESET = 8'h00;
    localparam logic [7:0] OUTPUT_DRIVE_RESET   = 8'h00;
    localparam logic [7:0] INPUT_TYPE_RESET     = 8'hff;

    // default number of bonded pins
    localparam int         PIN_COUNT_DEFAULT = 8;

    // byte access request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;

    // single bit access request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic       wdata;
    } bit_req_t;

endpackage : port_match_pkg

//--- core/mismatch_compare.sv
`timescale 1ns/1ps

module mismatch_compare
    import port_match_pkg::*;
#(
    parameter int WIDTH = PIN_COUNT_DEFAULT
) (
    // levels and settings
    input  wire logic [WIDTH-1:0] i_level,
    input  wire logic [WIDTH-1:0] i_enable,
    input  wire logic [WIDTH-1:0] i_expected,
    // result
    output logic                  o_mismatch
);

    logic [WIDTH-1:0] diff;

    // per pin difference against the selected reference
    assign diff = i_level ^ i_expected;

    // masked pins never contribute; any enabled difference raises it
    assign o_mismatch = |(diff & i_enable);

endmodule : mismatch_compare

//--- core/port_latch_match.sv
`timescale 1ns/1ps

// Notes on behaviour
// - masked pin never causes a mismatch
// - enabled pin compared with expected level bit
// - expected bit zero means low, one high
// - compare enables reset to zero
// - expected levels reset to one
// - latch write updates digital pins' output value
// - latch read returns live pin levels
// - latch zero drives low, one drives/floats high
// - latch allows bit and byte access
// - pin count parameter: eight, seven or four
// - drive select: zero open drain, one push-pull
// - analog pin: pullup, driver, receiver off
module port_latch_match
    import port_match_pkg::*;
#(
    parameter int PIN_COUNT = PIN_COUNT_DEFAULT
) (
    // clock and reset
    input  wire logic                 I_REF_CLK,
    input  wire logic                 I_ARST_N,
    // byte access port
    input  wire sfr_req_t             i_SFR_REQ,
    output logic [7:0]                o_SFR_RDATA,
    output logic                      o_SFR_RVALID,
    // bit access port
    input  wire bit_req_t             i_BIT_REQ,
    output logic                      o_BIT_RDATA,
    output logic                      o_BIT_RVALID,
    // port pins
    input  wire logic [PIN_COUNT-1:0] i_PIN_IN,
    output logic [PIN_COUNT-1:0]      o_PIN_OUT,
    output logic [PIN_COUNT-1:0]      o_PIN_OE,
    output logic [PIN_COUNT-1:0]      o_PULLUP_EN,
    // match event
    output logic                      o_MISMATCH
);

    logic [7:0]           pin_latch_reg;
    logic [7:0]           expected_level_reg;
    logic [7:0]           compare_enable_reg;
    logic [7:0]           output_drive_select_reg;
    logic [7:0]           input_type_select_reg;
    logic [7:0]           pin_level;
    logic [PIN_COUNT-1:0] rx_level;
    logic [PIN_COUNT-1:0] digital;
    logic                 bit_hit;
    logic [2:0]           bit_idx;
    logic                 mismatch_next;

    // receivers of analog pins read as low
    assign digital  = input_type_select_reg[PIN_COUNT-1:0];
    assign rx_level = i_PIN_IN & digital;

    // live pin levels, absent pins read zero
    always_comb begin
        pin_level = 8'h00;
        pin_level[PIN_COUNT-1:0] = rx_level;
    end

    // bit address decode for the latch
    assign bit_hit = (i_BIT_REQ.addr >= PIN_LATCH_BIT_BASE) &&
                     (i_BIT_REQ.addr <  PIN_LATCH_BIT_BASE +
                                        8'(PIN_LATCH_BIT_SPAN));
    assign bit_idx = 3'(i_BIT_REQ.addr - PIN_LATCH_BIT_BASE);

    // output latch, byte or single bit writes
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            pin_latch_reg <= PIN_LATCH_RESET;
        end else if (i_SFR_REQ.wr &&
                     i_SFR_REQ.addr == PIN_LATCH_ADDR) begin
            pin_latch_reg <= i_SFR_REQ.wdata;
        end else if (i_BIT_REQ.wr && bit_hit) begin
            pin_latch_reg[bit_idx] <= i_BIT_REQ.wdata;
        end
    end

    // expected level register
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            expected_level_reg <= EXPECTED_LEVEL_RESET;
        end else if (i_SFR_REQ.wr &&
                     i_SFR_REQ.addr == EXPECTED_LEVEL_ADDR) begin
            expected_level_reg <= i_SFR_REQ.wdata;
        end
    end

    // compare enable register
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            compare_enable_reg <= COMPARE_ENABLE_RESET;
        end else if (i_SFR_REQ.wr &&
                     i_SFR_REQ.addr == COMPARE_ENABLE_ADDR) begin
            compare_enable_reg <= i_SFR_REQ.wdata;
        end
    end

    // output drive and input type registers
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            output_drive_select_reg <= OUTPUT_DRIVE_RESET;
            input_type_select_reg   <= INPUT_TYPE_RESET;
        end else if (i_SFR_REQ.wr) begin
            if (i_SFR_REQ.addr == OUTPUT_DRIVE_ADDR) begin
                output_drive_select_reg <= i_SFR_REQ.wdata;
            end
            if (i_SFR_REQ.addr == INPUT_TYPE_ADDR) begin
                input_type_select_reg <= i_SFR_REQ.wdata;
            end
        end
    end

    // byte read, answered one cycle after the strobe
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            o_SFR_RDATA  <= 8'h00;
            o_SFR_RVALID <= 1'b0;
        end else begin
            o_SFR_RVALID <= i_SFR_REQ.rd;
            if (i_SFR_REQ.rd) begin
                case (i_SFR_REQ.addr)
                    PIN_LATCH_ADDR:      o_SFR_RDATA <= pin_level;
                    EXPECTED_LEVEL_ADDR: o_SFR_RDATA <= expected_level_reg;
                    COMPARE_ENABLE_ADDR: o_SFR_RDATA <= compare_enable_reg;
                    OUTPUT_DRIVE_ADDR:
                        o_SFR_RDATA <= output_drive_select_reg;
                    INPUT_TYPE_ADDR:     o_SFR_RDATA <= input_type_select_reg;
                    default:             o_SFR_RDATA <= 8'h00;
                endcase
            end
        end
    end

    // bit read of the latch returns the pin level
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            o_BIT_RDATA  <= 1'b0;
            o_BIT_RVALID <= 1'b0;
        end else begin
            o_BIT_RVALID <= i_BIT_REQ.rd;
            if (i_BIT_REQ.rd) begin
                o_BIT_RDATA <= bit_hit ? pin_level[bit_idx]
                                       : 1'b0;
            end
        end
    end

    // per pin drive: low driven on digital pins, high only when push-pull
    generate
        for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pin
            always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
                if (!I_ARST_N) begin
                    o_PIN_OUT[p]   <= 1'b1;
                    o_PIN_OE[p]    <= 1'b0;
                    o_PULLUP_EN[p] <= 1'b1;
                end else begin
                    o_PIN_OUT[p] <= pin_latch_reg[p];
                    // analog pins lose driver and pullup
                    o_PIN_OE[p] <= input_type_select_reg[p] &&
                                   (!pin_latch_reg[p] ||
                                    output_drive_select_reg[p]);
                    o_PULLUP_EN[p] <= input_type_select_reg[p];
                end
            end
        end
    endgenerate

    // pattern comparator over the bonded pins
    mismatch_compare #(
        .WIDTH      (PIN_COUNT)
    ) u_compare (
        .i_level    (rx_level),
        .i_enable   (compare_enable_reg[PIN_COUNT-1:0]),
        .i_expected (expected_level_reg[PIN_COUNT-1:0]),
        .o_mismatch (mismatch_next)
    );

    // registered mismatch level
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            o_MISMATCH <= 1'b0;
        end else begin
            o_MISMATCH <= mismatch_next;
        end
    end

endmodule : port_latch_match

//--- test/port_latch_match_asserts.sv
`timescale 1ns/1ps

module port_latch_match_asserts
    import port_match_pkg::*;
#(
    parameter int PIN_COUNT = PIN_COUNT_DEFAULT
) (
    // clock, reset and requests
    input  wire logic                 I_REF_CLK,
    input  wire logic                 I_ARST_N,
    input  wire sfr_req_t             i_SFR_REQ,
    input  wire bit_req_t             i_BIT_REQ,
    // answers, pins and event
    input  wire logic                 o_SFR_RVALID,
    input  wire logic                 o_BIT_RDATA,
    input  wire logic                 o_BIT_RVALID,
    input  wire logic [PIN_COUNT-1:0] o_PIN_OUT,
    input  wire logic [PIN_COUNT-1:0] o_PIN_OE,
    input  wire logic [PIN_COUNT-1:0] o_PULLUP_EN,
    input  wire logic                 o_MISMATCH
);
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_ARST_N);

    // latch byte write reaches the pins two edges later
    property p_latch_write;
        logic [7:0] d;
        (i_SFR_REQ.wr && i_SFR_REQ.addr == PIN_LATCH_ADDR, d = i_SFR_REQ.wdata)
            |=> ##1 o_PIN_OUT == d[PIN_COUNT-1:0];
    endproperty

    // read answers, pin drive relations and mismatch after reset
    a_rvalid_follows: assert property (
        i_SFR_REQ.rd |=> o_SFR_RVALID) else $error("byte read unanswered");
    a_rvalid_alone: assert property (
        !i_SFR_REQ.rd |=> !o_SFR_RVALID) else $error("stray read valid");
    a_bit_rvalid: assert property (
        i_BIT_REQ.rd |=> o_BIT_RVALID) else $error("bit read unanswered");
    a_bit_outside: assert property (
        i_BIT_REQ.rd && i_BIT_REQ.addr[7:3] != 5'h12 |=> !o_BIT_RDATA)
        else $error("bit read outside latch not zero");
    a_latch_write: assert property (p_latch_write)
        else $error("latch write not driven");
    a_low_driven: assert property (
        (~o_PIN_OUT & o_PULLUP_EN & ~o_PIN_OE) == '0)
        else $error("latch zero not driven low");
    a_analog_quiet: assert property (
        (o_PIN_OE & ~o_PULLUP_EN) == '0) else $error("analog pin driven");
    a_quiet_after_reset: assert property (
        $rose(I_ARST_N) |-> !o_MISMATCH [*2])
        else $error("mismatch right after reset");

    // main scenarios reached
    c_latch_write: cover property (i_SFR_REQ.wr && i_SFR_REQ.addr == 8'h90);
    c_mismatch: cover property ($rose(o_MISMATCH));
    c_bit_read: cover property (i_BIT_REQ.rd);
endmodule : port_latch_match_asserts

bind port_latch_match port_latch_match_asserts #(.PIN_COUNT(PIN_COUNT)) u_chk (
    .I_REF_CLK(I_REF_CLK), .I_ARST_N(I_ARST_N), .i_SFR_REQ(i_SFR_REQ),
    .i_BIT_REQ(i_BIT_REQ), .o_SFR_RVALID(o_SFR_RVALID),
    .o_BIT_RDATA(o_BIT_RDATA), .o_BIT_RVALID(o_BIT_RVALID),
    .o_PIN_OUT(o_PIN_OUT), .o_PIN_OE(o_PIN_OE),
    .o_PULLUP_EN(o_PULLUP_EN), .o_MISMATCH(o_MISMATCH));

//--- test/pin_partner.sv
`timescale 1ns/1ps

module pin_partner #(parameter int N = 8) (
    // clock and device side
    input  wire logic         clk,
    input  wire logic [N-1:0] drv, oe, pu,
    // outside drive and resolved level
    input  wire logic [N-1:0] ext_en, ext_val,
    output logic [N-1:0]      lvl
);
    logic [N-1:0] last;
    // floating pins without pullup flip, exposing stale reads
    always_ff @(posedge clk) last <= lvl;
    // device drive wins, then outside drive, then pullup
    always_comb for (int b = 0; b < N; b++)
        lvl[b] = oe[b] ? drv[b] : ext_en[b] ? ext_val[b] : pu[b] | ~last[b];
endmodule : pin_partner

//--- test/port_latch_match_bench.sv
`timescale 1ns/1ps

module port_latch_match_bench;
    import port_match_pkg::*;
    logic clk, arst_n, rvalid, brdata, brvalid, mis;
    sfr_req_t sreq;
    bit_req_t breq;
    logic [7:0] rdata, pin_out, oe, pu, lvl, ext_en, ext_val, v, e, x;
    int failures, n_compared, cyc = 0;
    logic [31:0] seed = 32'h5c32;

    port_latch_match i_dut (.I_REF_CLK(clk), .I_ARST_N(arst_n),
        .i_SFR_REQ(sreq), .o_SFR_RDATA(rdata), .o_SFR_RVALID(rvalid),
        .i_BIT_REQ(breq), .o_BIT_RDATA(brdata), .o_BIT_RVALID(brvalid),
        .i_PIN_IN(lvl), .o_PIN_OUT(pin_out), .o_PIN_OE(oe),
        .o_PULLUP_EN(pu), .o_MISMATCH(mis));
    pin_partner i_pins (.clk(clk), .drv(pin_out), .oe(oe), .pu(pu),
        .ext_en(ext_en), .ext_val(ext_val), .lvl(lvl));

    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd

    function automatic logic exp_mis(logic [7:0] p, logic [7:0] en,
                                     logic [7:0] lv);
        return |((p ^ lv) & en);
    endfunction : exp_mis

    task automatic chk(input logic [7:0] got, input logic [7:0] want);
        n_compared++;
        if (got !== want) begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, got, want);
        end
    endtask : chk

    // one byte request cycle; read data held afterwards
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        @(negedge clk);
        sreq <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge clk);
        sreq <= '0;
        if (!w) chk({7'h0, rvalid}, 8'h01);
    endtask : acc

    // one bit request cycle
    task automatic bacc(input logic w, input logic [7:0] a, input logic d);
        @(negedge clk);
        breq <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge clk);
        breq <= '0;
        if (!w) chk({7'h0, brvalid}, 8'h01);
    endtask : bacc

    task automatic print_verdict();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : print_verdict

    // clock generation
    initial begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end

    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            failures++;
            print_verdict();
        end
    end

    // main sequence
    initial begin
        arst_n = 0;
        sreq = '0;
        breq = '0;
        ext_en = '0;
        ext_val = '0;
        repeat (6) @(negedge clk);
        arst_n = 1;
        acc(0, COMPARE_ENABLE_ADDR, 0);
        chk(rdata, 8'h00);
        acc(0, EXPECTED_LEVEL_ADDR, 0);
        chk(rdata, 8'hff);
        acc(0, PIN_LATCH_ADDR, 0);
        chk(rdata, 8'hff);
        chk(oe, 8'h00);
        $display("reset test done");
        v = rnd();
        acc(1, PIN_LATCH_ADDR, v);
        repeat (2) @(negedge clk);
        chk(pin_out, v);
        chk(oe, ~v);
        acc(0, PIN_LATCH_ADDR, 0);
        chk(rdata, v);
        ext_en = 8'hff;
        acc(0, PIN_LATCH_ADDR, 0);
        chk(rdata, 8'h00);
        acc(1, OUTPUT_DRIVE_ADDR, 8'hff);
        ext_en = 8'h00;
        repeat (2) @(negedge clk);
        chk(oe, 8'hff);
        bacc(1, PIN_LATCH_BIT_BASE + 8'h3, ~v[3]);
        repeat (2) @(negedge clk);
        chk(pin_out, v ^ 8'h08);
        bacc(0, PIN_LATCH_BIT_BASE + 8'h3, 0);
        chk({7'h0, brdata}, {7'h0, ~v[3]});
        acc(1, OUTPUT_DRIVE_ADDR, 8'h00);
        acc(1, PIN_LATCH_ADDR, 8'hff);
        ext_en = 8'hff;
        $display("drive test done");
        // random compare patterns, first with all compares off
        for (int i = 0; i < 40; i++) begin
            e = (i == 0) ? 8'h00 : rnd();
            x = rnd();
            ext_val = rnd();
            if (i == 1) x = ext_val;
            acc(1, COMPARE_ENABLE_ADDR, e);
            acc(1, EXPECTED_LEVEL_ADDR, x);
            repeat (2) @(negedge clk);
            if (i == 0) chk(mis, 8'h00);
            chk(mis, exp_mis(ext_val, e, x));
        end
        $display("match test done");
        acc(1, INPUT_TYPE_ADDR, 8'hfe);
        ext_val = 8'hff;
        repeat (2) @(negedge clk);
        chk(pu, 8'hfe);
        acc(0, PIN_LATCH_ADDR, 0);
        chk(rdata, 8'hfe);
        acc(0, INPUT_TYPE_ADDR, 0);
        chk(rdata, 8'hfe);
        acc(0, 8'h91, 0);
        chk(rdata, 8'h00);
        bacc(0, PIN_LATCH_BIT_BASE + 8'h1, 0);
        chk({7'h0, brdata}, 8'h01);
        bacc(0, PIN_LATCH_BIT_BASE + 8'h8, 0);
        chk({7'h0, brdata}, 8'h00);
        // analog pin reads low, so it misses a high reference
        acc(1, COMPARE_ENABLE_ADDR, 8'h01);
        acc(1, EXPECTED_LEVEL_ADDR, 8'hff);
        repeat (2) @(negedge clk);
        chk(mis, 8'h01);
        $display("analog test done");
        // second reset in mid-run
        arst_n = 0;
        repeat (2) @(negedge clk);
        arst_n = 1;
        chk(mis, 8'h00);
        chk(pu, 8'hff);
        acc(0, EXPECTED_LEVEL_ADDR, 0);
        chk(rdata, 8'hff);
        acc(0, COMPARE_ENABLE_ADDR, 0);
        chk(rdata, 8'h00);
        $display("second reset test done");
        print_verdict();
    end
endmodule : port_latch_match_bench
